/* inc/wg_pkg.sv */
// register map, field layout, carriers and timing of the wake event and clock gating block
package wg_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, 16-bit registers)
    // ----------------------------------------------------------------
    localparam int          WG_ADDR_W         = 8;
    localparam int          WG_DATA_W         = 16;
    localparam logic [7:0]  WG_OFS_PM_STATUS  = 8'h32;
    localparam logic [7:0]  WG_OFS_WAKE_EN    = 8'h34;
    localparam logic [7:0]  WG_OFS_GO_SLEEP   = 8'h36;
    localparam logic [7:0]  WG_OFS_CLK_GATE   = 8'h38;

    // power_mode_and_wake_status fields
    localparam int          WG_ST_FRAME       = 5;
    localparam int          WG_ST_REMOTE      = 4;
    localparam int          WG_ST_LINK        = 3;
    localparam int          WG_ST_ENERGY      = 2;
    localparam int          WG_MODE_LSB       = 0;
    localparam logic [1:0]  WG_MODE_NORMAL    = 2'h0;
    localparam logic [1:0]  WG_MODE_ENERGY    = 2'h1;

    // wake_event_enable fields
    localparam int          WG_EN_POL         = 4;
    localparam int          WG_EN_FRAME       = 3;
    localparam int          WG_EN_REMOTE      = 2;
    localparam int          WG_EN_LINK        = 1;
    localparam int          WG_EN_ENERGY      = 0;
    localparam logic [4:0]  WG_WAKE_EN_RST    = 5'h00;

    // go_sleep_time and clock_gating_control fields
    localparam logic [7:0]  WG_GO_SLEEP_RST   = 8'h8e;
    localparam int          WG_CG_SW_EN       = 3;
    localparam int          WG_CG_CPU_EN      = 2;
    localparam int          WG_CG_WAIT_LSB    = 0;
    localparam logic [4:0]  WG_CLK_GATE_RST   = 5'h04;

    // ----------------------------------------------------------------
    // timing at 50 MHz
    // ----------------------------------------------------------------
    localparam longint      WG_CLK_PERIOD_NS  = 64'd20;
    localparam longint      WG_SLEEP_UNIT_NS  = 64'd20_000_000;
    localparam longint      WG_WAIT0_NS       = 64'd5_300_000_000;
    localparam longint      WG_WAIT1_NS       = 64'd1_600_000_000;
    localparam longint      WG_WAIT2_NS       = 64'd1_000_000;
    localparam longint      WG_WAIT3_NS       = 64'd3_200;

    // least times round up to whole cycles
    function automatic int wg_cycles(input longint t_ns);
        wg_cycles = int'((t_ns + WG_CLK_PERIOD_NS - 64'd1) / WG_CLK_PERIOD_NS);
    endfunction

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;
        logic        wr;
        logic        rd;
        logic [1:0]  be;
        logic [15:0] wdata;
    } wg_reg_req_type;

    typedef struct packed {
        logic        frame;
        logic        remote;
        logic [1:0]  link_up;
        logic [1:0]  energy;
    } wg_det_type;

endpackage

/* rtl/wg_idle_timer.sv */
// idle timer: counts cycles without activity against a selectable wait period
`timescale 1ns/1ps
module wg_idle_timer #(
    parameter int WAIT0_CYC = 1,
    parameter int WAIT1_CYC = 1,
    parameter int WAIT2_CYC = 1,
    parameter int WAIT3_CYC = 1
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       active_i,
    input  wire logic [1:0] sel_i,
    output logic            idle_o
);
    import wg_pkg::*;

    if (WAIT0_CYC < 1 || WAIT1_CYC < 1 || WAIT2_CYC < 1 || WAIT3_CYC < 1) begin : g_chk
        $error("wg_idle_timer: wait counts must be at least one cycle");
    end

    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic        idle_ff;
    logic        nxt_idle;
    logic [31:0] limit;

    // ----------------------------------------------------------------
    // wait period decode and counting
    // ----------------------------------------------------------------
    always_comb begin
        case (sel_i)
            2'h0:    limit = 32'(WAIT0_CYC);
            2'h1:    limit = 32'(WAIT1_CYC);
            2'h2:    limit = 32'(WAIT2_CYC);
            default: limit = 32'(WAIT3_CYC);
        endcase
        // saturates at the limit so a long idle never wraps back to busy
        if (active_i) begin
            nxt_cnt = 32'h0;
        end else if (cnt_ff < limit) begin
            nxt_cnt = cnt_ff + 32'h1;
        end else begin
            nxt_cnt = cnt_ff;
        end
        nxt_idle = !active_i && (nxt_cnt >= limit);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff  <= 32'h0;
            idle_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            idle_ff <= nxt_idle;
        end
    end

    assign idle_o = idle_ff;

    AST_IDLE_AFTER_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(idle_ff) |-> cnt_ff >= $past(limit) && !$past(active_i))
        else $error("idle flagged before the wait period ran out");

endmodule

/* rtl/wg_top.sv */
// wake request pin, go-sleep control and clock tree gating with their host registers
`timescale 1ns/1ps
module wg_top #(
    parameter int SLEEP_UNIT_CYC = wg_pkg::wg_cycles(wg_pkg::WG_SLEEP_UNIT_NS),
    parameter int WAIT0_CYC      = wg_pkg::wg_cycles(wg_pkg::WG_WAIT0_NS),
    parameter int WAIT1_CYC      = wg_pkg::wg_cycles(wg_pkg::WG_WAIT1_NS),
    parameter int WAIT2_CYC      = wg_pkg::wg_cycles(wg_pkg::WG_WAIT2_NS),
    parameter int WAIT3_CYC      = wg_pkg::wg_cycles(wg_pkg::WG_WAIT3_NS)
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire wg_pkg::wg_reg_req_type reg_req_i,
    input  wire wg_pkg::wg_det_type     det_i,
    input  wire logic [2:0]             mii_busy_i,
    input  wire logic                   host_activity_i,
    output logic [15:0]                 reg_rdata_o,
    output logic                        wake_request_pin_o,
    output logic                        low_power_o,
    output logic                        switch_clk_en_o,
    output logic                        cpu_clk_en_o,
    output logic [1:0]                  pm_mode_o
);
    import wg_pkg::*;

    if (SLEEP_UNIT_CYC < 1) begin : g_chk
        $error("wg_top: go-sleep unit must be at least one cycle");
    end

    typedef enum logic [1:0] {
        WG_AWAKE  = 2'b00,
        WG_WATCH  = 2'b01,
        WG_ASLEEP = 2'b10
    } wg_state_type;

    // ----------------------------------------------------------------
    // register access
    // ----------------------------------------------------------------
    logic [3:0]  flags_ff;   // frame, remote, link, energy
    logic [3:0]  nxt_flags;
    logic [1:0]  mode_ff;
    logic [1:0]  nxt_mode;
    logic [4:0]  wake_en_ff;
    logic [4:0]  nxt_wake_en;
    logic [7:0]  go_sleep_ff;
    logic [7:0]  nxt_go_sleep;
    logic [4:0]  cg_ff;
    logic [4:0]  nxt_cg;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic [3:0]  events;
    logic [3:0]  clr;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = a[7:1] == ofs[7:1];
    endfunction

    always_comb begin
        events = {det_i.frame, det_i.remote, |det_i.link_up, |det_i.energy};
        clr    = '0;
        if (reg_req_i.wr && reg_req_i.be[0] && hit(reg_req_i.addr, WG_OFS_PM_STATUS)) begin
            clr = reg_req_i.wdata[WG_ST_FRAME:WG_ST_ENERGY];
        end
        // an event in the same cycle as its clear keeps the flag set
        nxt_flags = events | (flags_ff & ~clr);
        nxt_mode     = mode_ff;
        nxt_wake_en  = wake_en_ff;
        nxt_go_sleep = go_sleep_ff;
        nxt_cg       = cg_ff;
        if (reg_req_i.wr && reg_req_i.be[0]) begin
            if (hit(reg_req_i.addr, WG_OFS_PM_STATUS)) begin
                nxt_mode = reg_req_i.wdata[WG_MODE_LSB +: 2];
            end
            if (hit(reg_req_i.addr, WG_OFS_WAKE_EN)) begin
                nxt_wake_en = reg_req_i.wdata[4:0];
            end
            if (hit(reg_req_i.addr, WG_OFS_GO_SLEEP)) begin
                nxt_go_sleep = reg_req_i.wdata[7:0];
            end
            if (hit(reg_req_i.addr, WG_OFS_CLK_GATE)) begin
                nxt_cg = reg_req_i.wdata[4:0];
            end
        end
        nxt_rdata = rdata_ff;
        if (reg_req_i.rd) begin
            nxt_rdata = 16'h0000;
            if (hit(reg_req_i.addr, WG_OFS_PM_STATUS)) begin
                nxt_rdata = {10'h000, flags_ff, mode_ff};
            end else if (hit(reg_req_i.addr, WG_OFS_WAKE_EN)) begin
                nxt_rdata = {11'h000, wake_en_ff};
            end else if (hit(reg_req_i.addr, WG_OFS_GO_SLEEP)) begin
                nxt_rdata = {8'h00, go_sleep_ff};
            end else if (hit(reg_req_i.addr, WG_OFS_CLK_GATE)) begin
                nxt_rdata = {11'h000, cg_ff};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_ff    <= 4'h0;
            mode_ff     <= WG_MODE_NORMAL;
            wake_en_ff  <= WG_WAKE_EN_RST;
            go_sleep_ff <= WG_GO_SLEEP_RST;
            cg_ff       <= WG_CLK_GATE_RST;
            rdata_ff    <= 16'h0000;
        end else begin
            flags_ff    <= nxt_flags;
            mode_ff     <= nxt_mode;
            wake_en_ff  <= nxt_wake_en;
            go_sleep_ff <= nxt_go_sleep;
            cg_ff       <= nxt_cg;
            rdata_ff    <= nxt_rdata;
        end
    end

    // ----------------------------------------------------------------
    // wake request pin
    // ----------------------------------------------------------------
    logic pin_ff;
    logic nxt_pin;
    logic wake_want;

    always_comb begin
        // flags keep the request up until software clears them
        wake_want = |(flags_ff & wake_en_ff[3:0]);
        nxt_pin   = wake_en_ff[WG_EN_POL] ? wake_want : !wake_want;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_ff <= 1'b1;
        end else begin
            pin_ff <= nxt_pin;
        end
    end

    // ----------------------------------------------------------------
    // go-sleep control in energy-detect mode
    // ----------------------------------------------------------------
    wg_state_type state_ff;
    wg_state_type nxt_state;
    logic [31:0]  tick_ff;
    logic [31:0]  nxt_tick;
    logic [7:0]   units_ff;
    logic [7:0]   nxt_units;
    logic         energy;
    logic         ed_mode;
    logic         lp_ff;
    logic         nxt_lp;

    always_comb begin
        energy    = |det_i.energy;
        ed_mode   = mode_ff == WG_MODE_ENERGY;
        nxt_state = state_ff;
        nxt_tick  = 32'h0;
        nxt_units = 8'h00;
        case (state_ff)
            WG_AWAKE: begin
                if (ed_mode && !energy) begin
                    nxt_state = WG_WATCH;
                end
            end
            WG_WATCH: begin
                // any energy restarts the whole interval, it must be unbroken
                if (!ed_mode || energy) begin
                    nxt_state = WG_AWAKE;
                end else if (units_ff >= go_sleep_ff) begin
                    nxt_state = WG_ASLEEP;
                end else if (tick_ff == 32'(SLEEP_UNIT_CYC - 1)) begin
                    nxt_units = units_ff + 8'h01;
                end else begin
                    nxt_tick  = tick_ff + 32'h1;
                    nxt_units = units_ff;
                end
            end
            WG_ASLEEP: begin
                if (!ed_mode || energy) begin
                    nxt_state = WG_AWAKE;
                end
            end
            default: nxt_state = WG_AWAKE;
        endcase
        nxt_lp = nxt_state == WG_ASLEEP;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= WG_AWAKE;
            tick_ff  <= 32'h0;
            units_ff <= 8'h00;
            lp_ff    <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            tick_ff  <= nxt_tick;
            units_ff <= nxt_units;
            lp_ff    <= nxt_lp;
        end
    end

    // ----------------------------------------------------------------
    // clock tree gating
    // ----------------------------------------------------------------
    logic sw_idle;
    logic cpu_idle;
    logic mii_any;
    logic host_any;
    logic sw_en_ff;
    logic nxt_sw_en;
    logic cpu_en_ff;
    logic nxt_cpu_en;

    assign mii_any  = |mii_busy_i;
    assign host_any = host_activity_i || reg_req_i.wr || reg_req_i.rd;

    wg_idle_timer #(
        .WAIT0_CYC (WAIT0_CYC),
        .WAIT1_CYC (WAIT1_CYC),
        .WAIT2_CYC (WAIT2_CYC),
        .WAIT3_CYC (WAIT3_CYC)
    ) u_sw_timer (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .active_i (mii_any),
        .sel_i    (cg_ff[WG_CG_WAIT_LSB +: 2]),
        .idle_o   (sw_idle)
    );

    wg_idle_timer #(
        .WAIT0_CYC (WAIT0_CYC),
        .WAIT1_CYC (WAIT1_CYC),
        .WAIT2_CYC (WAIT2_CYC),
        .WAIT3_CYC (WAIT3_CYC)
    ) u_cpu_timer (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .active_i (mii_any || host_any),
        .sel_i    (cg_ff[WG_CG_WAIT_LSB +: 2]),
        .idle_o   (cpu_idle)
    );

    always_comb begin
        // live activity overrides the registered idle so wake-up costs one cycle
        nxt_sw_en  = !(cg_ff[WG_CG_SW_EN] && sw_idle && !mii_any);
        nxt_cpu_en = !(cg_ff[WG_CG_CPU_EN] && cpu_idle && !mii_any && !host_any);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_en_ff  <= 1'b1;
            cpu_en_ff <= 1'b1;
        end else begin
            sw_en_ff  <= nxt_sw_en;
            cpu_en_ff <= nxt_cpu_en;
        end
    end

    assign reg_rdata_o        = rdata_ff;
    assign wake_request_pin_o = pin_ff;
    assign low_power_o        = lp_ff;
    assign switch_clk_en_o    = sw_en_ff;
    assign cpu_clk_en_o       = cpu_en_ff;
    assign pm_mode_o          = mode_ff;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_PIN_LEVEL: assert property ($past(wake_want) |-> wake_request_pin_o == $past(wake_en_ff[WG_EN_POL]))
        else $error("wake pin level does not follow polarity");
    AST_FRAME_WAKE: assert property (det_i.frame && wake_en_ff[WG_EN_FRAME] && !reg_req_i.wr ##1 !reg_req_i.wr
        |=> wake_request_pin_o == wake_en_ff[WG_EN_POL])
        else $error("wake-up frame did not raise the wake pin");
    AST_REMOTE_WAKE: assert property (det_i.remote && wake_en_ff[WG_EN_REMOTE] && !reg_req_i.wr ##1 !reg_req_i.wr
        |=> wake_request_pin_o == wake_en_ff[WG_EN_POL])
        else $error("remote wake did not raise the wake pin");
    AST_LINK_WAKE: assert property ((|det_i.link_up) && wake_en_ff[WG_EN_LINK] && !reg_req_i.wr ##1 !reg_req_i.wr
        |=> wake_request_pin_o == wake_en_ff[WG_EN_POL])
        else $error("link-up did not raise the wake pin");
    AST_MASKED_IDLE: assert property ((flags_ff & wake_en_ff[3:0]) == 4'h0 && $stable(wake_en_ff)
        |=> wake_request_pin_o == !$past(wake_en_ff[WG_EN_POL]))
        else $error("wake pin asserted with no enabled flag");
    AST_SLEEP_ENTRY: assert property ($rose(low_power_o) |-> $past(units_ff) >= $past(go_sleep_ff)
        && $past(ed_mode) && !$past(energy))
        else $error("low power entered before the go-sleep interval");
    AST_GO_SLEEP_RST: assert property ($past(rst_i) |-> go_sleep_ff == WG_GO_SLEEP_RST)
        else $error("go-sleep count has wrong reset value");
    AST_SW_ON: assert property (!cg_ff[WG_CG_SW_EN] |=> switch_clk_en_o)
        else $error("switch clock gated while auto shutdown is off");
    AST_SW_WAKE: assert property (!switch_clk_en_o && mii_any |=> switch_clk_en_o)
        else $error("switch clock not restarted on MII activity");
    AST_CPU_WAKE: assert property (!cpu_clk_en_o && (host_any || mii_any) |=> cpu_clk_en_o)
        else $error("cpu clock not restarted on activity");
    AST_CPU_GATE: assert property ($fell(cpu_clk_en_o) |-> $past(cg_ff[WG_CG_CPU_EN]) && $past(cpu_idle))
        else $error("cpu clock gated without idle");
    AST_FLAG_SET: assert property (det_i.remote |=> flags_ff[2])
        else $error("event flag not set");

    CVR_WAKE: cover property ($changed(wake_request_pin_o));
    CVR_SLEEP: cover property ($rose(low_power_o));
    CVR_SW_GATE: cover property ($fell(switch_clk_en_o) ##[1:50] $rose(switch_clk_en_o));

endmodule

/* tb/wg_host_model.sv */
// host side model: issues register writes and reads on the strobe port
`timescale 1ns/1ps
module wg_host_model (
    input  wire logic           clk_i,
    input  wire logic [15:0]    reg_rdata_i,
    output wg_pkg::wg_reg_req_type reg_req_o
);
    import wg_pkg::*;

    initial reg_req_o = '0;

    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    // one-cycle write strobe with be[0] set; used for mode changes too
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_i);
        reg_req_o = '{addr: a, wr: 1'b1, rd: 1'b0, be: 2'h1, wdata: d};
        @(negedge clk_i);
        reg_req_o = '0;
    endtask

    // data is taken a full cycle late; it stands until the next read
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk_i);
        reg_req_o = '{addr: a, wr: 1'b0, rd: 1'b1, be: 2'h0, wdata: 16'h0000};
        @(negedge clk_i);
        reg_req_o = '0;
        @(negedge clk_i);
        d = reg_rdata_i;
    endtask
endmodule

/* tb/wg_top_tb.sv */
// self-checking bench of the wake request and clock gating block
`timescale 1ns/1ps
module wg_top_tb;
    import wg_pkg::*;

    localparam int LIM [4] = '{40, 20, 10, 5};

    logic           clk;
    logic           rst;
    wg_reg_req_type req;
    wg_det_type     det;
    logic [2:0]     mii;
    logic           host_act;
    logic [15:0]    rdata;
    logic           pin;
    logic           low_pw;
    logic           sw_en;
    logic           cpu_en;
    logic [1:0]     mode;
    logic [15:0]    d;
    logic           pol;
    int             error_cnt;
    int             check_count;
    int             seed;
    int             cyc;
    int             fs;
    int             fc;

    wg_top #(.SLEEP_UNIT_CYC(4), .WAIT0_CYC(40), .WAIT1_CYC(20), .WAIT2_CYC(10), .WAIT3_CYC(5)) wg_top_i (
        .clk_i(clk), .rst_i(rst), .reg_req_i(req), .det_i(det), .mii_busy_i(mii),
        .host_activity_i(host_act), .reg_rdata_o(rdata), .wake_request_pin_o(pin),
        .low_power_o(low_pw), .switch_clk_en_o(sw_en), .cpu_clk_en_o(cpu_en), .pm_mode_o(mode));

    wg_host_model wg_host_model_i (.clk_i(clk), .reg_rdata_i(rdata), .reg_req_o(req));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic exp_pin(input logic act, input logic p);
        return p ? act : ~act;
    endfunction

    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic pulse_det(input int i);
        logic p;
        p = 1'($random(seed));
        @(negedge clk);
        case (i)
            0: det.frame = 1'b1;
            1: det.remote = 1'b1;
            2: det.link_up[p] = 1'b1;
            default: det.energy[p] = 1'b1;
        endcase
        @(negedge clk);
        det = '0;
    endtask

    // first cycle count at which each clock enable is seen low
    task automatic idle_run(input int lim);
        int n;
        n = 0;
        fs = -1;
        fc = -1;
        while ((fs < 0 || fc < 0) && n < lim + 8) begin
            @(negedge clk);
            n++;
            if (fs < 0 && sw_en === 1'b0) fs = n;
            if (fc < 0 && cpu_en === 1'b0) fc = n;
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0]  ra [5];
        logic [15:0] rv [5];
        ra = '{8'h32, 8'h34, 8'h36, 8'h38, 8'h3a};
        rv = '{16'h0000, 16'h0000, 16'h008e, 16'h0004, 16'h0000};
        seed = 15307;
        rst = 1'b1;
        det = '0;
        mii = 3'h0;
        host_act = 1'b0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        chk(pin === 1'b1 && mode === 2'h0, "reset outputs");
        wg_host_model_i.wr(8'h3a, 16'hffff);
        for (int k = 0; k < 5; k++) begin
            wg_host_model_i.rd(ra[k], d);
            chk(d === rv[k], "reset value");
        end
        // each source: disabled event only sets its flag, enabling later raises the pin
        for (int i = 0; i < 4; i++) begin
            pol = 1'($random(seed));
            wg_host_model_i.wr(8'h34, {11'h000, pol, 4'h0});
            pulse_det(i);
            repeat (3) @(negedge clk);
            chk(pin === exp_pin(1'b0, pol), "disabled source drove pin");
            wg_host_model_i.rd(8'h32, d);
            chk(d === (16'h0020 >> i), "sticky flag");
            wg_host_model_i.wr(8'h34, {11'h000, pol, 4'h8 >> i});
            repeat (3) @(negedge clk);
            chk(pin === exp_pin(1'b1, pol), "pin not asserted");
            wg_host_model_i.wr(8'h32, 16'h0020 >> i);
            repeat (3) @(negedge clk);
            chk(pin === exp_pin(1'b0, pol), "pin held after clear");
            pulse_det(i);
            repeat (3) @(negedge clk);
            chk(pin === exp_pin(1'b1, pol), "enabled event missed");
            wg_host_model_i.wr(8'h32, 16'h003c);
            wg_host_model_i.wr(8'h34, 16'h0000);
        end
        // go-sleep of two units in energy-detect mode
        wg_host_model_i.wr(8'h36, 16'h0002);
        wg_host_model_i.wr(8'h32, 16'h0001);
        chk(mode === 2'h1, "mode not stored");
        repeat (5) @(negedge clk);
        chk(low_pw === 1'b0, "low power too early");
        repeat (8) @(negedge clk);
        chk(low_pw === 1'b1, "low power not entered");
        pulse_det(3);
        chk(low_pw === 1'b0, "energy did not leave low power");
        wg_host_model_i.wr(8'h32, 16'h003c);
        chk(mode === 2'h0, "normal mode");
        // both clock gates over every wait code, woken by MII, then only the cpu gate by host
        for (int c = 0; c < 4; c++) begin
            wg_host_model_i.wr(8'h38, 16'h000c | 16'(c));
            // the switch timer saturates across iterations, so restart both timers from a known edge
            mii = 3'h1 << ($unsigned($random(seed)) % 3);
            @(negedge clk);
            mii = 3'h0;
            idle_run(LIM[c]);
            chk(fs >= LIM[c] - 1 && fs <= LIM[c] + 3, "switch gate time");
            chk(fc >= LIM[c] - 1 && fc <= LIM[c] + 3, "cpu gate time");
            @(negedge clk);
            mii = 3'h1 << ($unsigned($random(seed)) % 3);
            @(negedge clk);
            mii = 3'h0;
            @(negedge clk);
            chk(sw_en === 1'b1 && cpu_en === 1'b1, "mii wake");
            idle_run(LIM[c]);
            host_act = 1'b1;
            @(negedge clk);
            host_act = 1'b0;
            @(negedge clk);
            chk(cpu_en === 1'b1 && sw_en === 1'b0, "host wake");
        end
        wg_host_model_i.wr(8'h38, 16'h0003);
        repeat (20) @(negedge clk);
        chk(sw_en === 1'b1 && cpu_en === 1'b1, "disabled gate shut clock");
        close_out();
    end

    initial begin
        error_cnt = 0;
        check_count = 0;
        cyc = 0;
    end
endmodule
